// >>> src/smps_top.sv
// Summary of operation
// [R1] A 24-bit window length in three bytes; low byte resets 0x80, others zero.
// [R2] Software writes only even window lengths; odd values are undefined.
// [R3] Writing one to the update bit snapshots result and count; bit self-clears.
// [R4] Result selection 001, the reset value, routes peak data to readback.
// [R5] Result is 20 bits over two bytes and a low nibble; upper nibble zero.
// [R6] An 8-bit read-only window counter increments on each period expiry.
// [R7] Two-bit framer enable: 00 off, 11 on, resets off.
// [R8] Each framer input select bit includes its statistic in the frame; only bit 1 (peak) is kept, the other bits are masked to zero.
// [R9] Framer select bit 1 inserts peak data; it resets to one.
// [R10] Next-sync mode uses only the next sysref edge, then clears sync enable.
// [R11] Peak tracks the window maximum, latches at expiry, then restarts.
`timescale 1ns/100ps
`default_nettype none
`include "smps_defs.svh"
module smps_top
  import smps_pkg::*;
#(
  parameter int RES_W = 20
)
(
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic [19:0] sample_mag_i,
  input  wire logic        sample_valid_i,
  input  wire logic        sysref_i,
  output logic             stat_frame_valid_o,
  output logic      [19:0] stat_frame_peak_o,
  output logic      [7:0]  stat_frame_count_o
);
  smps_pk_if pk ();

  smps_period_t period_r;
  smps_period_t period_nxt;
  smps_period_t cnt_r;
  smps_period_t cnt_nxt;
  logic [2:0]   sel_r;
  logic [2:0]   sel_nxt;
  logic         upd_r;
  logic         upd_nxt;
  logic [1:0]   sync_r;
  logic [1:0]   sync_nxt;
  logic [1:0]   fen_r;
  logic [1:0]   fen_nxt;
  logic [7:0]   insel_r;
  logic [7:0]   insel_nxt;
  logic [7:0]   frame_r;
  logic [7:0]   frame_nxt;
  smps_result_t snap_r;
  smps_result_t snap_nxt;
  logic [7:0]   snap_cnt_r;
  logic [7:0]   snap_cnt_nxt;
  logic [7:0]   rdata_nxt;
  logic         fv_nxt;
  smps_result_t fpeak_nxt;
  logic [7:0]   fcnt_nxt;
  logic         sr_q1;
  logic         sr_q2;
  logic         sr_q3;
  logic         sr_edge;
  logic         restart;
  logic         expire;
  smps_period_t reload;

  // Sysref pin passes two flops; the third only feeds edge detection.
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      sr_q1 <= 1'b0;
      sr_q2 <= 1'b0;
      sr_q3 <= 1'b0;
    end
    else
    begin
      sr_q1 <= sysref_i;
      sr_q2 <= sr_q1;
      sr_q3 <= sr_q2;
    end
  end

  // Window timing, sync restart and peak tracker control.
  always_comb
  begin
    sr_edge = sr_q2 & ~sr_q3;
    // [R10] Sync restart.
    restart = sync_r[`SMPS_SYNC_EN_BIT] & sr_edge;
    // [R2] Odd lengths are not guarded; zero acts as one.
    reload  = (period_r == '0) ? '0 : period_r - 24'h000001;
    expire  = (cnt_r == '0) & ~restart;
    cnt_nxt = (restart | expire) ? reload : cnt_r - 24'h000001;
    // [R6] Window count.
    frame_nxt = expire ? frame_r + 8'h01 : frame_r;
    pk.sample = sample_mag_i;
    pk.valid  = sample_valid_i;
    pk.clear  = restart;
    pk.latch  = expire;
  end

  // Register writes and their side effects.
  always_comb
  begin
    period_nxt   = period_r;
    sel_nxt      = sel_r;
    sync_nxt     = sync_r;
    fen_nxt      = fen_r;
    insel_nxt    = insel_r;
    upd_nxt      = 1'b0;
    snap_nxt     = snap_r;
    snap_cnt_nxt = snap_cnt_r;
    // [R10] Clear enable after one edge.
    if (restart && sync_r[`SMPS_SYNC_NEXT_BIT])
    begin
      sync_nxt[`SMPS_SYNC_EN_BIT] = 1'b0;
    end
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        // [R1] Window length bytes.
        `SMPS_PERIOD0_ADDR: period_nxt[7:0]   = reg_wdata_i;
        `SMPS_PERIOD1_ADDR: period_nxt[15:8]  = reg_wdata_i;
        `SMPS_PERIOD2_ADDR: period_nxt[23:16] = reg_wdata_i;
        `SMPS_SYNC_CTL_ADDR: sync_nxt = reg_wdata_i[1:0];
        `SMPS_RB_CTL_ADDR:
        begin
          sel_nxt = reg_wdata_i[2:0];
          upd_nxt = reg_wdata_i[`SMPS_UPDATE_BIT];
        end
        // [R7] Framer enable.
        `SMPS_FRAMER_EN_ADDR: fen_nxt = reg_wdata_i[1:0];
        `SMPS_INSEL_ADDR: insel_nxt = reg_wdata_i & `SMPS_INSEL_MASK;
        default: ;
      endcase
    end
    // [R3] Snapshot on update.
    if (upd_r)
    begin
      // [R4] Route peak result.
      snap_nxt     = (sel_r == `SMPS_SEL_PEAK) ? pk.result : '0;
      snap_cnt_nxt = frame_r;
    end
  end

  // Readback data, framer insertion.
  always_comb
  begin
    case (reg_addr_i)
      `SMPS_SYNC_CTL_ADDR:  rdata_nxt = {6'h00, sync_r};
      `SMPS_PERIOD0_ADDR:   rdata_nxt = period_r[7:0];
      `SMPS_PERIOD1_ADDR:   rdata_nxt = period_r[15:8];
      `SMPS_PERIOD2_ADDR:   rdata_nxt = period_r[23:16];
      // [R3] Update bit reads as pending only.
      `SMPS_RB_CTL_ADDR:    rdata_nxt = {3'h0, upd_r, 1'b0, sel_r};
      `SMPS_RESULT0_ADDR:   rdata_nxt = snap_r[7:0];
      `SMPS_RESULT1_ADDR:   rdata_nxt = snap_r[15:8];
      // [R5] Upper nibble zero.
      `SMPS_RESULT2_ADDR:   rdata_nxt = {4'h0, snap_r[19:16]};
      `SMPS_WIN_CNT_ADDR:   rdata_nxt = snap_cnt_r;
      `SMPS_FRAMER_EN_ADDR: rdata_nxt = {6'h00, fen_r};
      `SMPS_INSEL_ADDR:     rdata_nxt = insel_r;
      default:              rdata_nxt = 8'h00;
    endcase
    if (!reg_rd_i)
    begin
      rdata_nxt = reg_rdata_o;
    end
    // [R8] Insert selected statistics.
    fv_nxt    = expire && (fen_r == `SMPS_FRAMER_ON) && (insel_r != 8'h00);
    // [R9] Peak data field.
    fpeak_nxt = insel_r[`SMPS_INSEL_PEAK_BIT] ? pk.result_nxt : '0;
    fcnt_nxt  = frame_nxt;
    if (!fv_nxt)
    begin
      fpeak_nxt = stat_frame_peak_o;
      fcnt_nxt  = stat_frame_count_o;
    end
  end

  // Register all state except the sysref synchroniser flops.
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      period_r           <= `SMPS_PERIOD_RST;
      cnt_r              <= `SMPS_PERIOD_RST - 24'h000001; // First window is one length.
      sel_r              <= `SMPS_SEL_RST;
      upd_r              <= 1'b0;
      sync_r             <= 2'h0;
      fen_r              <= `SMPS_FRAMER_OFF;
      insel_r            <= `SMPS_INSEL_RST;
      frame_r            <= 8'h00;
      snap_r             <= '0;
      snap_cnt_r         <= 8'h00;
      reg_rdata_o        <= 8'h00;
      stat_frame_valid_o <= 1'b0;
      stat_frame_peak_o  <= '0;
      stat_frame_count_o <= 8'h00;
    end
    else
    begin
      period_r           <= period_nxt;
      cnt_r              <= cnt_nxt;
      sel_r              <= sel_nxt;
      upd_r              <= upd_nxt;
      sync_r             <= sync_nxt;
      fen_r              <= fen_nxt;
      insel_r            <= insel_nxt;
      frame_r            <= frame_nxt;
      snap_r             <= snap_nxt;
      snap_cnt_r         <= snap_cnt_nxt;
      reg_rdata_o        <= rdata_nxt;
      stat_frame_valid_o <= fv_nxt;
      stat_frame_peak_o  <= fpeak_nxt;
      stat_frame_count_o <= fcnt_nxt;
    end
  end

  smps_peak u_peak (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .pk        (pk.peak)
  );

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  period_reset_val_a: assert property (@(posedge sys_clk_i) // [R1]
    $fell(srst_i) |-> (period_r == `SMPS_PERIOD_RST) && (fen_r == `SMPS_FRAMER_OFF))
    else $error("Window length or framer enable wrong after reset.");
  snapshot_copy_a: assert property ( // [R3]
    (upd_r && sel_r == `SMPS_SEL_PEAK) |=> (snap_r == $past(pk.result))
      && (snap_cnt_r == $past(frame_r)))
    else $error("Snapshot did not copy result and count.");
  update_self_clear_a: assert property ( // [R3]
    (reg_wr_i && reg_addr_i == `SMPS_RB_CTL_ADDR && reg_wdata_i[`SMPS_UPDATE_BIT]) |=> upd_r
      ##1 (!upd_r || $past(reg_wr_i && reg_addr_i == `SMPS_RB_CTL_ADDR
                           && reg_wdata_i[`SMPS_UPDATE_BIT])))
    else $error("Update bit did not self-clear.");
  route_select_a: assert property ( // [R4]
    (upd_r && sel_r != `SMPS_SEL_PEAK) |=> (snap_r == '0))
    else $error("Unselected source reached readback.");
  result_nibble_a: assert property ( // [R5]
    $past(reg_rd_i && reg_addr_i == `SMPS_RESULT2_ADDR)
      |-> (reg_rdata_o == {4'h0, $past(snap_r[19:16])}))
    else $error("Upper result nibble not zero.");
  window_count_a: assert property ( // [R6]
    expire |=> (frame_r == $past(frame_r) + 8'h01))
    else $error("Window counter did not advance on expiry.");
  framer_insert_a: assert property ( // [R7]
    stat_frame_valid_o == $past(expire && fen_r == 2'h3 && insel_r[1]))
    else $error("Framer insertion mismatch.");
  window_length_a: assert property ( // [R1]
    (expire && period_r == 24'h000008 && !reg_wr_i) ##1 (!restart)[*8] |-> expire)
    else $error("Window did not expire after its length.");
  next_sync_a: assert property ( // [R10]
    (restart && sync_r[1] && !reg_wr_i) |=> !sync_r[0] ##1 !restart)
    else $error("Next-sync mode did not clear enable.");
  frame_peak_a: assert property ( // [R9]
    (stat_frame_valid_o && $past(insel_r[`SMPS_INSEL_PEAK_BIT]))
      |-> (stat_frame_peak_o == pk.result))
    else $error("Frame peak is not the window just closed.");
endmodule : smps_top
`default_nettype wire

// >>> src/smps_defs.svh
`ifndef SMPS_DEFS_SVH
`define SMPS_DEFS_SVH
// Register offsets of the signal monitor statistics unit.
`define SMPS_SYNC_CTL_ADDR    16'h026F
`define SMPS_PERIOD0_ADDR     16'h0271
`define SMPS_PERIOD1_ADDR     16'h0272
`define SMPS_PERIOD2_ADDR     16'h0273
`define SMPS_RB_CTL_ADDR      16'h0274
`define SMPS_RESULT0_ADDR     16'h0275
`define SMPS_RESULT1_ADDR     16'h0276
`define SMPS_RESULT2_ADDR     16'h0277
`define SMPS_WIN_CNT_ADDR     16'h0278
`define SMPS_FRAMER_EN_ADDR   16'h0279
`define SMPS_INSEL_ADDR       16'h027A
// Field positions.
`define SMPS_SYNC_EN_BIT      0
`define SMPS_SYNC_NEXT_BIT    1
`define SMPS_UPDATE_BIT       4
`define SMPS_INSEL_PEAK_BIT   1
// Reset values and codes.
`define SMPS_PERIOD_RST       24'h000080
`define SMPS_SEL_RST          3'h1
`define SMPS_SEL_PEAK         3'h1
`define SMPS_FRAMER_OFF       2'h0
`define SMPS_FRAMER_ON        2'h3
`define SMPS_INSEL_RST        8'h02
`define SMPS_INSEL_MASK       8'h02
`endif

// >>> src/smps_pkg.sv
package smps_pkg;
  // Peak result and window length types.
  typedef logic [19:0] smps_result_t;
  typedef logic [23:0] smps_period_t;
endpackage : smps_pkg

// >>> src/smps_pk_if.sv
`timescale 1ns/100ps
`default_nettype none
// Carrier between the window timing logic and the peak tracker.
interface smps_pk_if;
  logic [19:0] sample;
  logic        valid;
  logic        clear;
  logic        latch;
  logic [19:0] result;
  // Value the result takes at the next edge, so the framer sees the window just closed.
  logic [19:0] result_nxt;
  modport ctrl (output sample, output valid, output clear, output latch, input result,
                input result_nxt);
  modport peak (input sample, input valid, input clear, input latch, output result,
                output result_nxt);
endinterface : smps_pk_if
`default_nettype wire

// >>> src/smps_peak.sv
`timescale 1ns/100ps
`default_nettype none
// Tracks the largest magnitude in a window and latches it at window end.
module smps_peak
  import smps_pkg::*;
(
  input  wire logic  sys_clk_i,
  input  wire logic  srst_i,
  smps_pk_if.peak    pk
);
  smps_result_t max_r;
  smps_result_t max_nxt;
  smps_result_t res_r;
  smps_result_t res_nxt;
  smps_result_t cand;

  // Next running maximum and held result.
  always_comb
  begin
    cand    = (pk.valid && (pk.sample > max_r)) ? pk.sample : max_r;
    max_nxt = cand;
    res_nxt = res_r;
    if (pk.clear)
    begin
      max_nxt = '0;
    end
    // [R11] Latch and restart.
    else if (pk.latch)
    begin
      res_nxt = cand;
      max_nxt = pk.valid ? pk.sample : '0;
    end
  end

  // Register the tracker state.
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      max_r <= '0;
      res_r <= '0;
    end
    else
    begin
      max_r <= max_nxt;
      res_r <= res_nxt;
    end
  end

  // Held result, and the value latched at the coming edge for the framer.
  assign pk.result     = res_r;
  assign pk.result_nxt = res_nxt;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  peak_latch_a: assert property ( // [R11]
    (pk.latch && !pk.clear && !(pk.valid && pk.sample > max_r)) |=> (pk.result == $past(max_r)))
    else $error("Peak result does not hold the window maximum.");
  peak_track_a: assert property ( // [R11]
    (!pk.clear && !pk.latch && pk.valid && pk.sample > max_r) |=> (max_r == $past(pk.sample)))
    else $error("Peak tracker missed a larger sample.");
endmodule : smps_peak
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "smps_defs.svh"
module tb_top
  import smps_pkg::*;
;
  logic        sys_clk_i      = 1'b0;
  logic        srst_i         = 1'b1;
  logic [15:0] reg_addr_i     = 16'h0000;
  logic        reg_wr_i       = 1'b0;
  logic [7:0]  reg_wdata_i    = 8'h00;
  logic        reg_rd_i       = 1'b0;
  logic [7:0]  reg_rdata_o;
  logic [19:0] sample_mag_i   = 20'h00000;
  logic        sample_valid_i = 1'b0;
  logic        sysref_i       = 1'b0;
  logic        stat_frame_valid_o;
  logic [19:0] stat_frame_peak_o;
  logic [7:0]  stat_frame_count_o;
  int          fails          = 0;
  int          tests_run      = 0;
  int          cycles         = 0;

  // Device under test with plain port connections.
  smps_top dut
  (
    .sys_clk_i          (sys_clk_i),
    .srst_i             (srst_i),
    .reg_addr_i         (reg_addr_i),
    .reg_wr_i           (reg_wr_i),
    .reg_wdata_i        (reg_wdata_i),
    .reg_rd_i           (reg_rd_i),
    .reg_rdata_o        (reg_rdata_o),
    .sample_mag_i       (sample_mag_i),
    .sample_valid_i     (sample_valid_i),
    .sysref_i           (sysref_i),
    .stat_frame_valid_o (stat_frame_valid_o),
    .stat_frame_peak_o  (stat_frame_peak_o),
    .stat_frame_count_o (stat_frame_count_o)
  );

  // Free-running clock of 20 ns.
  initial
  begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // Cuts a hung run short after a generous cycle ceiling.
  always @(posedge sys_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      summarize();
    end
  end

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b0;
    @(posedge sys_clk_i);
    #1 d = reg_rdata_o;
  endtask : reg_read

  // Waits for a frame pulse, returning the edges waited (300 if none came).
  task automatic wait_frame(output int n);
    n = 0;
    do
    begin
      @(posedge sys_clk_i);
      #1 n++;
    end while (stat_frame_valid_o !== 1'b1 && n < 300);
  endtask : wait_frame

  task automatic t_reset_values;
    logic [15:0] ra [11];
    logic [7:0]  rv [11];
    logic [7:0]  d;
    ra = '{16'h026F, 16'h0271, 16'h0272, 16'h0273, 16'h0274, 16'h0275,
           16'h0276, 16'h0277, 16'h0278, 16'h0279, 16'h027A};
    rv = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02};
    for (int i = 0; i < 11; i++)
    begin
      reg_read(ra[i], d);
      check(d, rv[i]);
    end
  endtask : t_reset_values

  task automatic t_windows;
    int         n;
    logic [7:0] c;
    logic [7:0] d;
    @(posedge sys_clk_i);
    sample_mag_i   <= 20'hABCDE;
    sample_valid_i <= 1'b1;
    reg_write(`SMPS_PERIOD0_ADDR, 8'h08);
    reg_write(`SMPS_FRAMER_EN_ADDR, 8'h03);
    repeat (3) wait_frame(n);
    c = stat_frame_count_o;
    wait_frame(n);
    check(20'(n), 20'h00008);
    check(stat_frame_count_o, 8'(c + 8'h01));
    check(stat_frame_peak_o, 20'hABCDE);
    @(posedge sys_clk_i);
    sample_mag_i <= 20'h00010;
    repeat (2) wait_frame(n);
    check(stat_frame_peak_o, 20'h00010);
    // A large sample without its qualifier must not raise the peak.
    @(posedge sys_clk_i);
    sample_mag_i   <= 20'hFFFFF;
    sample_valid_i <= 1'b0;
    wait_frame(n);
    check(stat_frame_peak_o, 20'h00010);
    @(posedge sys_clk_i);
    sample_mag_i   <= 20'hABCDE;
    sample_valid_i <= 1'b1;
    repeat (3) wait_frame(n);
    c = stat_frame_count_o;
    reg_write(`SMPS_RB_CTL_ADDR, 8'h11);
    repeat (3) @(posedge sys_clk_i);
    reg_read(`SMPS_RESULT0_ADDR, d);
    check(d, 8'hDE);
    reg_read(`SMPS_RESULT1_ADDR, d);
    check(d, 8'hBC);
    reg_read(`SMPS_RESULT2_ADDR, d);
    check(d, 8'h0A);
    reg_read(`SMPS_WIN_CNT_ADDR, d);
    check(d, c);
    reg_read(`SMPS_RB_CTL_ADDR, d);
    check(d, 8'h01);
    reg_write(`SMPS_RESULT0_ADDR, 8'hFF);
    reg_read(`SMPS_RESULT0_ADDR, d);
    check(d, 8'hDE);
    // A selection other than the peak detector snapshots zero.
    reg_write(`SMPS_RB_CTL_ADDR, 8'h10);
    repeat (3) @(posedge sys_clk_i);
    reg_read(`SMPS_RESULT0_ADDR, d);
    check(d, 8'h00);
    reg_read(`SMPS_RB_CTL_ADDR, d);
    check(d, 8'h00);
    reg_write(`SMPS_RB_CTL_ADDR, 8'h01);
  endtask : t_windows

  task automatic t_framer;
    int n;
    for (int code = 0; code < 3; code++)
    begin
      reg_write(`SMPS_FRAMER_EN_ADDR, 8'(code));
      repeat (10) @(posedge sys_clk_i);
      wait_frame(n);
      check(stat_frame_valid_o, 1'b0);
    end
    reg_write(`SMPS_INSEL_ADDR, 8'h00);
    reg_write(`SMPS_FRAMER_EN_ADDR, 8'h03);
    repeat (10) @(posedge sys_clk_i);
    wait_frame(n);
    check(stat_frame_valid_o, 1'b0);
    reg_write(`SMPS_INSEL_ADDR, 8'h02);
    wait_frame(n);
    check(stat_frame_valid_o, 1'b1);
  endtask : t_framer

  task automatic t_sync;
    int         n;
    logic [7:0] d;
    reg_write(`SMPS_SYNC_CTL_ADDR, 8'h03);
    @(posedge sys_clk_i);
    sysref_i <= 1'b1;
    // The synchronised edge restarts the window three edges after the pin rises.
    repeat (3) @(posedge sys_clk_i);
    wait_frame(n);
    check(20'(n), 20'h00008);
    @(posedge sys_clk_i);
    sysref_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    sysref_i <= 1'b1;
    // A later edge lands on a natural expiry and must be ignored.
    wait_frame(n);
    check(20'(n), 20'h00003);
    @(posedge sys_clk_i);
    sysref_i <= 1'b0;
    reg_read(`SMPS_SYNC_CTL_ADDR, d);
    check(d, 8'h02);
    // Upper window length bytes read back as written.
    reg_write(`SMPS_PERIOD1_ADDR, 8'hA5);
    reg_write(`SMPS_PERIOD2_ADDR, 8'h5A);
    reg_read(`SMPS_PERIOD1_ADDR, d);
    check(d, 8'hA5);
    reg_read(`SMPS_PERIOD2_ADDR, d);
    check(d, 8'h5A);
  endtask : t_sync

  // Main sequence: reset, then each scenario in turn.
  initial
  begin
    repeat (4) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    t_reset_values();
    t_windows();
    t_framer();
    t_sync();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
